/* rtcw_core.sv */
// Purpose: Clock watch, alarm compare, interrupt flags and countdown timer
// Assumes: Low-speed clock arrives as a pin and is sampled on core_clk_in
// Notes:   Register reads answer one cycle after the read strobe
//
// Notes on behaviour
// R1 - Bank decoded at fixed base, word offsets
// R2 - Now register: seconds, minutes, hours fields
// R3 - Seconds/minutes 0..59, hours 0..23
// R4 - Weekday 1..7, reset value one
// R5 - Day limited by month and leap year
// R6 - Month 1..12, reset value one
// R7 - Now register resets to 0x02120000
// R8 - Year now and year alarm reset 0x2000
// R9 - Alarm seconds 0x3C..0x3F never match
// R10 - Alarm minutes 0x3C upward never match
// R11 - Alarm hours 0x18..0x1F never match
// R12 - Alarm weekday zero means ignore
// R13 - Alarm day zero means ignore
// R14 - Interrupt mask read/write, resets masked
// R15 - Raw and masked status read-only, zero
// R16 - Clear register write-only, clears status bits
// R17 - Trim register read/write, reset 0x7FFF
// R18 - Countdown value readable, not writable
// R19 - Timer control read/write, resets zero
// R20 - Two reload registers, reset zero
// R21 - Reload pattern over four words
// R22 - Timer interrupt count read-only
// R23 - Seconds advance on each one-hertz tick
// R24 - Preset copied at next tick
// R25 - Alarm raised after increment on match
// R26 - Interrupt output ORs both sources
// R27 - Full calendar rollover into year
// R28 - Software loads only legal calendar values
//
// Chosen here: the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none

module rtcw_core (
	input  wire logic              core_clk_in,
	input  wire logic              rst_n_in,
	input  wire rtcw_pkg::rtcw_bus_t bus_in,
	input  wire logic              slow_clk_in,
	output logic [31:0]            rdata_out,
	output logic                   irq_out
);
	import rtcw_pkg::*;

	rtcw_state_t q;
	rtcw_state_t d;

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	// Two BCD digits divisible by four
	function automatic logic div4(input logic [7:0] v);
		return v[4] ? (v[3:0] == 4'h2 || v[3:0] == 4'h6)
		            : (v[3:0] == 4'h0 || v[3:0] == 4'h4 || v[3:0] == 4'h8);
	endfunction

	// Century years leap only when the hundreds divide by four
	function automatic logic is_leap(input logic [13:0] y);
		return (y[7:0] == 8'h00) ? div4({2'b00, y[13:8]}) : div4(y[7:0]);
	endfunction

	function automatic logic [4:0] days_in(input logic [3:0] m,
	                                        input logic       lp);
		case (m)
			4'h2:                      return lp ? 5'h1D : 5'h1C;
			4'h4, 4'h6, 4'h9, 4'hB:    return 5'h1E;
			default:                   return 5'h1F;
		endcase
	endfunction

	// BCD year step; top digit holds only two bits
	function automatic logic [13:0] bcd_inc(input logic [13:0] y);
		logic [15:0] v;
		logic        c;
		v = {2'b00, y};
		c = 1'b1;
		for (int i = 0; i < 4; i++) begin
			if (c) begin
				if (v[i*4 +: 4] == 4'h9) begin
					v[i*4 +: 4] = 4'h0;
				end else begin
					v[i*4 +: 4] = v[i*4 +: 4] + 4'h1;
					c = 1'b0;
				end
			end
		end
		return v[13:0];
	endfunction

	// Pattern words sit at four consecutive word offsets
	function automatic logic is_pat(input logic [7:0] o);
		return (o >= OFS_PAT0) && (o <= OFS_PAT3);
	endfunction

	// Lowest pattern bit held by the word at this offset
	function automatic logic [6:0] pat_lsb(input logic [7:0] o);
		logic [7:0] w;
		w = o - OFS_PAT0;
		return {w[3:2], 5'h00};
	endfunction

	// ----------------------------------------------------------------
	// Decode and compare
	// ----------------------------------------------------------------
	logic       hit;
	logic [7:0] ofs;
	logic       wr;
	logic       rd;
	logic       ls_rise;
	logic       tick;
	logic       cal_match;
	logic       running;
	logic [6:0] plen;

	// Upper address must equal the base; sub-word addresses miss
	assign hit = (bus_in.addr[31:8] == BASE_ADDR[31:8]) // R1
	          && (bus_in.addr[1:0] == 2'b00);
	assign ofs = bus_in.addr[7:0];
	assign wr  = bus_in.wr & hit;
	assign rd  = bus_in.rd & hit;
	assign running = q.tctl[TC_RUN_BIT];
	assign plen    = q.tctl[TC_PLEN_LSB +: 7];

	// Filtered level goes high only after two stages agree
	assign ls_rise = (q.ls_sync[2:1] == 2'b11) & ~q.ls_lvl;
	assign tick    = ls_rise & (q.presc == '0); // R23

	// Out-of-range codes kill the match; zero weekday, day, month and year codes are ignored
	assign cal_match =
		(q.alarm.sec <= SEC_MAX) && (q.alarm.sec == q.now.sec) // R9
		&& (q.alarm.min <= SEC_MAX) && (q.alarm.min == q.now.min) // R10
		&& (q.alarm.hour <= HOUR_MAX) // R11
		&& (q.alarm.hour == q.now.hour)
		&& (q.alarm.wday == '0 || q.alarm.wday == q.now.wday) // R12
		&& (q.alarm.mday == '0 || q.alarm.mday == q.now.mday) // R13
		&& (q.alarm.month <= MONTH_MAX)
		&& (q.alarm.month == '0 || q.alarm.month == q.now.month)
		&& (q.year_alarm == '0 || q.year_alarm == q.year);

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	// Order matters: flag sets follow bus writes so a set beats a clear
	always_comb begin
		d = q;
		d.cmp_pend = 1'b0;
		d.rdata    = '0;
		d.ls_sync  = {q.ls_sync[1:0], slow_clk_in};
		if (q.ls_sync[2] == q.ls_sync[1]) begin
			d.ls_lvl = q.ls_sync[2];
		end
		if (ls_rise) begin
			d.presc = (q.presc == '0) ? q.trim[PRESC_W-1:0] : q.presc - 1'b1;
		end

		// Calendar step on the one-hertz tick
		if (tick) begin
			d.cmp_pend = ~q.load_pend;
			if (q.load_pend) begin
				d.now       = q.preset; // R24
				d.year      = q.year_preset;
				d.load_pend = 1'b0;
			end else if (q.now.sec != SEC_MAX) begin
				d.now.sec = q.now.sec + 1'b1; // R23
			end else begin
				d.now.sec = '0; // R3
				if (q.now.min != SEC_MAX) begin
					d.now.min = q.now.min + 1'b1;
				end else begin
					d.now.min = '0; // R27
					if (q.now.hour != HOUR_MAX) begin
						d.now.hour = q.now.hour + 1'b1;
					end else begin
						d.now.hour = '0; // R3
						d.now.wday = (q.now.wday == WDAY_MAX) ? 3'h1 // R4
						           : q.now.wday + 1'b1;
						if (q.now.mday < days_in(q.now.month, is_leap(q.year))) begin
							d.now.mday = q.now.mday + 1'b1;
						end else begin
							d.now.mday = 5'h01; // R5
							if (q.now.month != MONTH_MAX) begin
								d.now.month = q.now.month + 1'b1;
							end else begin
								d.now.month = 4'h1; // R6
								d.year      = bcd_inc(q.year); // R27
							end
						end
					end
				end
			end
		end

		// Countdown on each low-speed rising edge while enabled
		if (ls_rise && running) begin
			if (q.cnt == '0) begin
				d.countdown_irq_count  = q.countdown_irq_count + 1'b1; // R22
				d.cnt  = q.pat[q.pidx] ? q.rl_b : q.rl_a; // R21
				d.pidx = (q.pidx >= plen) ? '0 : q.pidx + 1'b1;
				if (q.tctl[TC_ONE_BIT]) begin
					d.tctl[TC_RUN_BIT] = 1'b0;
				end
			end else begin
				d.cnt = q.cnt - 1'b1;
			end
		end

		// Register writes
		if (wr) begin
			case (ofs)
				OFS_CAL_ALM: d.alarm = bus_in.wdata;
				OFS_CAL_PRE: begin
					d.preset    = bus_in.wdata;
					d.load_pend = 1'b1; // R24
				end
				OFS_YR_ALM:  d.year_alarm  = bus_in.wdata[13:0];
				OFS_YR_PRE:  d.year_preset = bus_in.wdata[13:0];
				OFS_TRIM: begin
					d.trim  = bus_in.wdata; // R17
					// Restart the divider so a new trim acts at once
					d.presc = bus_in.wdata[PRESC_W-1:0];
				end
				OFS_MASK:    d.mask = bus_in.wdata[1:0]; // R14
				OFS_CLR:     d.raw  = q.raw & ~bus_in.wdata[1:0]; // R16
				OFS_TCTL: begin
					d.tctl = bus_in.wdata; // R19
					// Fresh start reloads from the first value
					if (bus_in.wdata[TC_RUN_BIT] && !running) begin
						d.cnt  = q.rl_a;
						d.pidx = '0;
					end
				end
				// Reload values are locked while the timer runs
				OFS_RLA: if (!running) d.rl_a = bus_in.wdata; // R20
				OFS_RLB: if (!running) d.rl_b = bus_in.wdata;
				default: begin
					if (is_pat(ofs)) begin
						d.pat[pat_lsb(ofs) +: 32] = bus_in.wdata; // R21
					end
				end
			endcase
		end

		// Hardware sets after writes so a same-cycle clear loses
		if (q.cmp_pend && cal_match) begin
			d.raw[IRQ_CAL_BIT] = 1'b1; // R25
		end
		if (ls_rise && running && q.cnt == '0) begin
			d.raw[IRQ_TMR_BIT] = 1'b1;
		end

		// Read answer, registered for the next cycle
		if (rd) begin
			case (ofs)
				OFS_CAL_NOW: d.rdata = {3'b000, q.now[28:0]}; // R2
				OFS_CAL_ALM: d.rdata = q.alarm;
				OFS_CAL_PRE: d.rdata = q.preset;
				OFS_YR_NOW:  d.rdata = {18'h0, q.year};
				OFS_YR_ALM:  d.rdata = {18'h0, q.year_alarm};
				OFS_YR_PRE:  d.rdata = {18'h0, q.year_preset};
				OFS_TRIM:    d.rdata = q.trim;
				OFS_MASK:    d.rdata = {30'h0, q.mask};
				OFS_RAW:     d.rdata = {30'h0, q.raw}; // R15
				OFS_MSKD:    d.rdata = {30'h0, q.raw & q.mask};
				OFS_CNT:     d.rdata = q.cnt; // R18
				OFS_TCTL:    d.rdata = q.tctl;
				OFS_RLA:     d.rdata = q.rl_a;
				OFS_RLB:     d.rdata = q.rl_b;
				OFS_TIN:     d.rdata = q.countdown_irq_count;
				default: begin
					if (is_pat(ofs)) begin
						d.rdata = q.pat[pat_lsb(ofs) +: 32];
					end
				end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// State register
	// ----------------------------------------------------------------
	always_ff @(posedge core_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			q            <= '0;
			q.now        <= CAL_RST; // R7
			q.year       <= YEAR_RST; // R8
			q.year_alarm <= YEAR_RST;
			q.trim       <= TRIM_RST;
			q.cnt        <= CNT_RST;
			q.presc      <= TRIM_RST[PRESC_W-1:0];
		end else begin
			q <= d;
		end
	end

	assign rdata_out = q.rdata;
	assign irq_out   = |(q.raw & q.mask); // R26

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	a_sec_range: assert property ( // R3
		@(posedge core_clk_in) disable iff (!rst_n_in)
		q.now.sec <= SEC_MAX && q.now.min <= SEC_MAX
		&& q.now.hour <= HOUR_MAX)
		else $error("time field out of range");

	a_wday_legal: assert property ( // R4
		@(posedge core_clk_in) disable iff (!rst_n_in)
		q.now.wday != 3'h0)
		else $error("weekday zero");

	a_day_limit: assert property ( // R5
		@(posedge core_clk_in) disable iff (!rst_n_in)
		q.now.mday <= days_in(q.now.month, is_leap(q.year)))
		else $error("day beyond month length");

	a_sec_step: assert property ( // R23
		@(posedge core_clk_in) disable iff (!rst_n_in)
		(tick && !q.load_pend && q.now.sec < SEC_MAX)
		|=> q.now.sec == $past(q.now.sec) + 6'h1)
		else $error("seconds did not step on tick");

	a_preset_load: assert property ( // R24
		@(posedge core_clk_in) disable iff (!rst_n_in)
		(tick && q.load_pend) |=> q.now == $past(q.preset))
		else $error("preset not loaded on tick");

	a_alarm_raise: assert property ( // R25
		@(posedge core_clk_in) disable iff (!rst_n_in)
		(q.cmp_pend && cal_match) |=> q.raw[IRQ_CAL_BIT])
		else $error("alarm flag not raised");

	a_sec_never: assert property ( // R9
		@(posedge core_clk_in) disable iff (!rst_n_in)
		(q.alarm.sec > SEC_MAX) |-> !cal_match)
		else $error("match with invalid seconds code");

	a_clear_timer: assert property ( // R16
		@(posedge core_clk_in) disable iff (!rst_n_in)
		(wr && ofs == OFS_CLR && bus_in.wdata[IRQ_TMR_BIT]
		 && !(ls_rise && running && q.cnt == '0)) |=> !q.raw[IRQ_TMR_BIT])
		else $error("timer flag not cleared");

	a_year_read: assert property ( // R8
		@(posedge core_clk_in) disable iff (!rst_n_in)
		(rd && ofs == OFS_YR_NOW) |=> rdata_out == {18'h0, $past(q.year)})
		else $error("year read mismatch");

	a_reload_lock: assert property ( // R20
		@(posedge core_clk_in) disable iff (!rst_n_in)
		(wr && ofs == OFS_RLA && running) |=> q.rl_a == $past(q.rl_a))
		else $error("reload value changed while running");

	a_cnt_ro: assert property ( // R18
		@(posedge core_clk_in) disable iff (!rst_n_in)
		(wr && ofs == OFS_CNT && !running) |=> q.cnt == $past(q.cnt))
		else $error("countdown value took a write");

	a_tin_step: assert property ( // R22
		@(posedge core_clk_in) disable iff (!rst_n_in)
		(ls_rise && running && q.cnt == '0) |=> q.countdown_irq_count == $past(q.countdown_irq_count) + 32'h1)
		else $error("interrupt count did not step");

endmodule // rtcw_core
`default_nettype wire

/* rtcw_core_tb.sv */
// Purpose: Self-checking bench for the clock watch register bank
// Assumes: Trim is zeroed before any slow rise, so each rise is a tick
// Notes:   Bus changes right after rising edges; reads sampled 1 ns late
`timescale 1ns/1ps
`default_nettype none

module rtcw_core_tb;
	import rtcw_pkg::*;

	logic        clk = 1'b0;
	logic        rst_n = 1'b0;
	logic        slow = 1'b0;
	rtcw_bus_t   bus = '0;
	logic [31:0] rdata;
	logic        irq;
	logic [31:0] v;
	int          err_total = 0;
	int          checks_done = 0;

	// Reset image of the whole bank, word offsets 0x00..0x4C
	localparam logic [31:0] RST_VAL [20] = '{32'h0212_0000, 32'h0, 32'h0,
		32'h2000, 32'h2000, 32'h0, 32'h7FFF, 32'h0, 32'h0, 32'h0, 32'h0,
		32'h0FFF_FFFF, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0,
		32'h0};
	localparam logic [7:0]  RO_OFS [6] = '{8'h00, 8'h0C, 8'h20, 8'h24,
		8'h2C, 8'h4C};
	localparam logic [7:0]  RW_OFS [10] = '{8'h04, 8'h08, 8'h10, 8'h14,
		8'h1C, 8'h34, 8'h38, 8'h3C, 8'h40, 8'h44};
	localparam logic [31:0] RW_MSK [10] = '{32'hFFFF_FFFF, 32'hFFFF_FFFF,
		32'h3FFF, 32'h3FFF, 32'h3, 32'hFFFF_FFFF, 32'hFFFF_FFFF,
		32'hFFFF_FFFF, 32'hFFFF_FFFF, 32'hFFFF_FFFF};
	// Alarm words and whether midnight of a new year matches them
	localparam logic [31:0] ALM [9] = '{32'h0, 32'h3C, 32'h3F, 32'hF00,
		32'h1_8000, 32'h2_0000, 32'h4_0000, 32'h10_0000, 32'h20_0000};
	localparam logic        HIT [9] = '{1'b1, 1'b0, 1'b0, 1'b0, 1'b0,
		1'b1, 1'b0, 1'b1, 1'b0};

	// ------------------------------------------------------------
	// Clock and device
	// ------------------------------------------------------------
	always #12.5 clk = ~clk;

	rtcw_core i_rtcw_core (
		.core_clk_in (clk),
		.rst_n_in    (rst_n),
		.bus_in      (bus),
		.slow_clk_in (slow),
		.rdata_out   (rdata),
		.irq_out     (irq)
	);

	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	function automatic logic [31:0] cal(input int s, mi, h, w, d, mo);
		return {3'h0, mo[3:0], d[4:0], w[2:0], h[4:0], mi[5:0], s[5:0]};
	endfunction

	task automatic chk(input string what, input logic [31:0] seen,
		input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			err_total++;
			$display("BAD %s expected %h seen %h", what, exp, seen);
		end
	endtask

	// One-cycle write strobe
	task automatic wr(input logic [7:0] ofs, input logic [31:0] d);
		@(posedge clk);
		bus.addr <= BASE_ADDR | {24'h0, ofs};
		bus.wdata <= d;
		bus.wr <= 1'b1;
		@(posedge clk);
		bus.wr <= 1'b0;
	endtask

	// Read data stands only in the cycle after the strobe
	task automatic rda(input logic [31:0] a);
		@(posedge clk);
		bus.addr <= a;
		bus.rd <= 1'b1;
		@(posedge clk);
		bus.rd <= 1'b0;
		#1 v = rdata;
	endtask

	task automatic rc(input logic [7:0] ofs, input logic [31:0] exp);
		rda(BASE_ADDR | {24'h0, ofs});
		chk($sformatf("offset %h", ofs), v, exp);
	endtask

	// Long pulses so the three-flop filter always sees the rise
	task automatic tick();
		@(posedge clk);
		slow <= 1'b1;
		repeat (8) @(posedge clk);
		slow <= 1'b0;
		repeat (8) @(posedge clk);
	endtask

	// First tick loads the preset, second one increments
	task automatic roll(input logic [31:0] t, input logic [31:0] y);
		wr(OFS_YR_PRE, y);
		wr(OFS_CAL_PRE, t);
		tick();
		tick();
	endtask

	task automatic rollc(input logic [31:0] t, y, et, ey);
		roll(t, y);
		rc(OFS_CAL_NOW, et);
		rc(OFS_YR_NOW, ey);
	endtask

	task automatic finish_test();
		$display("checks %0d mismatches %0d", checks_done, err_total);
		if (err_total == 0 && checks_done > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	// ------------------------------------------------------------
	// Tests
	// ------------------------------------------------------------
	initial begin
		repeat (16) @(posedge clk);
		rst_n <= 1'b1;
		// Second pass proves writes to read-only places do nothing
		for (int p = 0; p < 2; p++) begin
			for (int i = 0; i < 20; i++)
				rc(8'(i * 4), RST_VAL[i]);
			foreach (RO_OFS[j])
				wr(RO_OFS[j], 32'hFFFF_FFFF);
		end
		$display("done: reset values");

		// Trim first so that every later slow rise is a tick
		wr(OFS_TRIM, 32'h0);
		rc(OFS_TRIM, 32'h0);
		foreach (RW_OFS[j]) begin
			wr(RW_OFS[j], 32'h15A5_A5A5);
			rc(RW_OFS[j], 32'h15A5_A5A5 & RW_MSK[j]);
		end
		// Top word differs so the word order shows in its readback; the countdown uses only pattern bit 0
		wr(OFS_PAT3, 32'hC000_0000);
		rc(OFS_PAT3, 32'hC000_0000);
		wr(OFS_CLR, 32'hFFFF_FFFF);
		rc(OFS_CLR, 32'h0);
		rda(32'h40F1_0000);
		chk("other base", v, 32'h0);
		rc(8'h50, 32'h0);
		rc(OFS_YR_NOW, 32'h2000);
		@(posedge clk);
		#1 chk("data after slot", rdata, 32'h0);
		$display("done: access kinds");

		rollc(cal(58, 7, 5, 2, 9, 3), 32'h2001, cal(59, 7, 5, 2, 9, 3), 32'h2001);
		rollc(cal(59, 59, 23, 7, 31, 12), 32'h1999, 32'h0212_0000, 32'h2000);
		rollc(cal(59, 59, 23, 3, 28, 2), 32'h2001, cal(0, 0, 0, 4, 1, 3), 32'h2001);
		rollc(cal(59, 59, 23, 3, 28, 2), 32'h2004, cal(0, 0, 0, 4, 29, 2), 32'h2004);
		rollc(cal(59, 59, 23, 2, 30, 4), 32'h2001, cal(0, 0, 0, 3, 1, 5), 32'h2001);
		$display("done: calendar counting");

		wr(OFS_MASK, 32'h1);
		wr(OFS_YR_ALM, 32'h2000);
		for (int i = 0; i < 9; i++) begin
			wr(OFS_CAL_ALM, ALM[i]);
			wr(OFS_CLR, 32'h3);
			roll(cal(59, 59, 23, 7, 31, 12), 32'h1999);
			rc(OFS_RAW, {31'h0, HIT[i]});
			chk("irq", {31'h0, irq}, {31'h0, HIT[i]});
		end
		// Masked source: flag stands but the line stays low
		wr(OFS_CAL_ALM, 32'h0);
		wr(OFS_MASK, 32'h0);
		wr(OFS_CLR, 32'h3);
		roll(cal(59, 59, 23, 7, 31, 12), 32'h1999);
		rc(OFS_RAW, 32'h1);
		rc(OFS_MSKD, 32'h0);
		chk("irq masked", {31'h0, irq}, 32'h0);
		wr(OFS_MASK, 32'h1);
		rc(OFS_MSKD, 32'h1);
		chk("irq unmasked", {31'h0, irq}, 32'h1);
		wr(OFS_CLR, 32'h1);
		rc(OFS_RAW, 32'h0);
		chk("irq cleared", {31'h0, irq}, 32'h0);
		$display("done: alarm compare");

		// One-shot countdown from two
		wr(OFS_CAL_ALM, 32'h3C);
		wr(OFS_MASK, 32'h2);
		wr(OFS_RLA, 32'h2);
		wr(OFS_TCTL, 32'h3);
		rc(OFS_TCTL, 32'h3);
		rc(OFS_CNT, 32'h2);
		wr(OFS_RLA, 32'h9);
		rc(OFS_RLA, 32'h2);
		repeat (3) tick();
		rc(OFS_RAW, 32'h2);
		rc(OFS_TIN, 32'h1);
		rc(OFS_TCTL, 32'h2);
		rc(OFS_CNT, 32'h15A5_A5A5);
		chk("irq timer", {31'h0, irq}, 32'h1);
		wr(OFS_CLR, 32'h2);
		rc(OFS_RAW, 32'h0);
		chk("irq timer off", {31'h0, irq}, 32'h0);
		$display("done: countdown");
		finish_test();
	end

	// Watchdog, far beyond the fewer than one thousand cycles the tests need
	initial begin
		repeat (20000) @(posedge clk);
		err_total++;
		finish_test();
	end

endmodule // rtcw_core_tb
`default_nettype wire

/* rtcw_pkg.sv */
// Purpose: Shared constants and types for the clock watch register bank
// Assumes: 32-bit word bus, byte addresses, binary time fields, BCD year
// Notes:   State of the block travels as one packed struct
`default_nettype none

package rtcw_pkg;

	// ----------------------------------------------------------------
	// Address map
	// ----------------------------------------------------------------
	localparam logic [31:0] BASE_ADDR    = 32'h40F0_0000;
	localparam logic [7:0]  OFS_CAL_NOW  = 8'h00;
	localparam logic [7:0]  OFS_CAL_ALM  = 8'h04;
	localparam logic [7:0]  OFS_CAL_PRE  = 8'h08;
	localparam logic [7:0]  OFS_YR_NOW   = 8'h0C;
	localparam logic [7:0]  OFS_YR_ALM   = 8'h10;
	localparam logic [7:0]  OFS_YR_PRE   = 8'h14;
	localparam logic [7:0]  OFS_TRIM     = 8'h18;
	localparam logic [7:0]  OFS_MASK     = 8'h1C;
	localparam logic [7:0]  OFS_RAW      = 8'h20;
	localparam logic [7:0]  OFS_MSKD     = 8'h24;
	localparam logic [7:0]  OFS_CLR      = 8'h28;
	localparam logic [7:0]  OFS_CNT      = 8'h2C;
	localparam logic [7:0]  OFS_TCTL     = 8'h30;
	localparam logic [7:0]  OFS_RLA      = 8'h34;
	localparam logic [7:0]  OFS_RLB      = 8'h38;
	localparam logic [7:0]  OFS_PAT0     = 8'h3C;
	localparam logic [7:0]  OFS_PAT3     = 8'h48;
	localparam logic [7:0]  OFS_TIN      = 8'h4C;

	// ----------------------------------------------------------------
	// Reset values, limits and bit positions
	// ----------------------------------------------------------------
	localparam logic [31:0] CAL_RST      = 32'h0212_0000;
	localparam logic [13:0] YEAR_RST     = 14'h2000;
	localparam logic [31:0] TRIM_RST     = 32'h0000_7FFF;
	localparam logic [31:0] CNT_RST      = 32'h0FFF_FFFF;
	localparam logic [5:0]  SEC_MAX      = 6'h3B;
	localparam logic [4:0]  HOUR_MAX     = 5'h17;
	localparam logic [2:0]  WDAY_MAX     = 3'h7;
	localparam logic [3:0]  MONTH_MAX    = 4'hC;
	localparam int          IRQ_CAL_BIT  = 0;
	localparam int          IRQ_TMR_BIT  = 1;
	localparam int          TC_RUN_BIT   = 0;
	localparam int          TC_ONE_BIT   = 1;
	localparam int          TC_PLEN_LSB  = 4;
	localparam int          PRESC_W      = 15;

	// Calendar word, fields at their register positions
	typedef struct packed {
		logic [2:0] rsvd;
		logic [3:0] month;
		logic [4:0] mday;
		logic [2:0] wday;
		logic [4:0] hour;
		logic [5:0] min;
		logic [5:0] sec;
	} rtcw_cal_t;

	typedef struct packed {
		logic [31:0] addr;
		logic [31:0] wdata;
		logic        wr;
		logic        rd;
	} rtcw_bus_t;

	typedef struct packed {
		rtcw_cal_t    now;
		rtcw_cal_t    alarm;
		rtcw_cal_t    preset;
		logic [13:0]  year;
		logic [13:0]  year_alarm;
		logic [13:0]  year_preset;
		logic [31:0]  trim;
		logic [1:0]   mask;
		logic [1:0]   raw;
		logic [31:0]  cnt;
		logic [31:0]  tctl;
		logic [31:0]  rl_a;
		logic [31:0]  rl_b;
		logic [127:0] pat;
		logic [6:0]   pidx;
		logic [31:0]  countdown_irq_count;
		logic [14:0]  presc;
		logic         load_pend;
		logic         cmp_pend;
		logic [2:0]   ls_sync;
		logic         ls_lvl;
		logic [31:0]  rdata;
	} rtcw_state_t;

endpackage
`default_nettype wire
